// ==== core/omsel_pkg.sv ====
// omsel_pkg: constants and types for the operation mode selector
package omsel_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_OPMODE = 8'h00;
  localparam logic [7:0] OFS_STARTUP = 8'h04;
  localparam logic [7:0] OFS_NETSRC = 8'h08;
  localparam logic [7:0] OFS_USERGRP = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_FUNC_BASE = 8'h20;
  localparam logic [2:0] FUNC_PAGE = 3'h1;
  localparam int unsigned FUNC_IDX_LSB = 2;
  localparam int unsigned FUNC_IDX_W = 3;
  // ==========================================================================
  // operation mode select values
  localparam logic [2:0] OPM_FREE = 3'h0;
  localparam logic [2:0] OPM_PANEL = 3'h1;
  localparam logic [2:0] OPM_EXT = 3'h2;
  localparam logic [2:0] OPM_COMB_A = 3'h3;
  localparam logic [2:0] OPM_COMB_B = 3'h4;
  localparam logic [2:0] OPM_BAD = 3'h5;
  localparam logic [2:0] OPM_LIVE = 3'h6;
  localparam logic [2:0] OPM_ILOCK = 3'h7;
  localparam logic [2:0] OPM_RESET = 3'h0;
  // ==========================================================================
  // start-up mode select values
  localparam logic [3:0] SUM_FOLLOW = 4'h0;
  localparam logic [3:0] SUM_NET = 4'h1;
  localparam logic [3:0] SUM_TOGGLE = 4'hA;
  localparam logic [3:0] SUM_RESET = 4'h0;
  // ==========================================================================
  // input terminal function codes
  localparam logic [7:0] FN_PU_EXT = 8'h10;
  localparam logic [7:0] FN_PU_NET = 8'h41;
  localparam logic [7:0] FN_EXT_NET = 8'h42;
  localparam logic [7:0] FN_RESET = 8'h00;
  // ==========================================================================
  // status layout
  localparam int unsigned STAT_MODE_LSB = 0;
  localparam int unsigned STAT_STOP_BIT = 2;
  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    OMSEL_PANEL = 2'b00,
    OMSEL_EXTERNAL = 2'b01,
    OMSEL_NETWORK = 2'b10,
    OMSEL_COMBINED = 2'b11
  } omsel_mode_t;

  typedef struct packed {
    logic pu_net;
    logic ext_net;
    logic pu_ext;
    logic pu_net_asg;
    logic ext_net_asg;
    logic pu_ext_asg;
  } omsel_sw_t;

  typedef struct packed {
    omsel_mode_t mode;
    logic output_stop;
  } omsel_stat_t;
endpackage : omsel_pkg

// ==== core/omsel_sync.sv ====
// omsel_sync: two-flop synchroniser, one chain per bit
module omsel_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end
endmodule : omsel_sync

// ==== core/omsel_top.sv ====
// omsel_top: operation mode selector with APB configuration registers
module omsel_top
  import omsel_pkg::*;
#(
  parameter int unsigned NUM_TERM = 7
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // terminals and drive state
  input wire logic [NUM_TERM-1:0] terminal_in,
  input wire logic pu_interlock_in,
  input wire logic motor_running,
  input wire logic start_cmd,
  input wire logic comm_option_fitted,
  input wire logic power_restore,
  // mode outputs
  output omsel_stat_t stat_out
);
  // ==========================================================================
  // input synchronisation
  logic [NUM_TERM:0] sync_s;
  logic [NUM_TERM-1:0] term_s;
  logic ilk_s;

  omsel_sync #(.WIDTH(NUM_TERM + 1)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({pu_interlock_in, terminal_in}),
    .sync_out(sync_s)
  );
  assign term_s = sync_s[NUM_TERM-1:0];
  assign ilk_s = sync_s[NUM_TERM];

  // ==========================================================================
  // registers
  logic [2:0] opm_q;
  logic [3:0] sum_q;
  logic netsrc_q;
  logic usergrp_q;
  logic [7:0] func_q [NUM_TERM];
  omsel_mode_t mode_q;
  omsel_mode_t mode_d;
  logic init_q;
  logic stop_q;

  logic stopped;
  logic wr_en;
  logic [FUNC_IDX_W-1:0] fidx;
  logic func_hit;
  logic opm_ok;
  logic sum_ok;
  logic cfg_ok;
  logic [31:0] rdata_d;
  logic err_d;

  assign stopped = !motor_running || !start_cmd;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign fidx = paddr[FUNC_IDX_LSB +: FUNC_IDX_W];
  assign func_hit = (paddr[7:5] == FUNC_PAGE) && (32'(fidx) < NUM_TERM) && (paddr[1:0] == 2'h0);
  assign opm_ok = pwdata[2:0] != OPM_BAD && pwdata[31:3] == '0;
  assign sum_ok = pwdata[31:4] == '0 &&
    (pwdata[3:0] == SUM_FOLLOW || pwdata[3:0] == SUM_NET || pwdata[3:0] == SUM_TOGGLE);
  assign cfg_ok = stopped;

  // ==========================================================================
  // terminal function mapping
  logic [NUM_TERM-1:0] hit65, hit66, hit16;
  omsel_sw_t sw;

  for (genvar i = 0; i < NUM_TERM; i++) begin : g_term
    assign hit65[i] = func_q[i] == FN_PU_NET;
    assign hit66[i] = func_q[i] == FN_EXT_NET;
    assign hit16[i] = func_q[i] == FN_PU_EXT;
  end

  assign sw.pu_net = |(hit65 & term_s);
  assign sw.ext_net = |(hit66 & term_s);
  assign sw.pu_ext = |(hit16 & term_s);
  assign sw.pu_net_asg = |hit65;
  assign sw.ext_net_asg = |hit66;
  assign sw.pu_ext_asg = |hit16;

  // ==========================================================================
  // apb decode and response
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (func_hit) begin
      rdata_d[7:0] = func_q[fidx];
    end else begin
      case (paddr)
        OFS_OPMODE: begin
          rdata_d[2:0] = opm_q;
          err_d = pwrite && !(opm_ok && cfg_ok);
        end
        OFS_STARTUP: begin
          rdata_d[3:0] = sum_q;
          err_d = pwrite && !(sum_ok && cfg_ok && (!usergrp_q || comm_option_fitted));
        end
        OFS_NETSRC: begin
          rdata_d[0] = netsrc_q;
        end
        OFS_USERGRP: begin
          rdata_d[0] = usergrp_q;
        end
        OFS_STATUS: begin
          rdata_d[STAT_MODE_LSB +: 2] = mode_q;
          rdata_d[STAT_STOP_BIT] = stop_q;
          err_d = pwrite;
        end
        default: begin
          err_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && err_d;
      prdata <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opm_q <= OPM_RESET;
      sum_q <= SUM_RESET;
      netsrc_q <= 1'b0;
      usergrp_q <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        OFS_OPMODE: opm_q <= pwdata[2:0];
        OFS_STARTUP: sum_q <= pwdata[3:0];
        OFS_NETSRC: netsrc_q <= pwdata[0];
        OFS_USERGRP: usergrp_q <= pwdata[0];
        default: ;
      endcase
    end
  end

  for (genvar i = 0; i < NUM_TERM; i++) begin : g_func
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        func_q[i] <= FN_RESET;
      end else if (wr_en && func_hit && 32'(fidx) == i) begin
        func_q[i] <= pwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // mode resolution
  logic net_to_panel_65;
  logic net_to_panel_66;
  logic toggle_cfg;
  logic start_now;

  assign net_to_panel_65 = !sw.pu_ext || (!netsrc_q && !comm_option_fitted);
  assign net_to_panel_66 = netsrc_q && !comm_option_fitted;
  assign toggle_cfg = sum_q == SUM_TOGGLE;
  assign start_now = init_q || power_restore;

  always_comb begin
    mode_d = mode_q;
    if (start_now) begin
      case (opm_q)
        OPM_PANEL: mode_d = OMSEL_PANEL;
        OPM_COMB_A, OPM_COMB_B: mode_d = OMSEL_COMBINED;
        OPM_ILOCK: mode_d = (sum_q == SUM_NET && ilk_s) ? OMSEL_NETWORK : OMSEL_EXTERNAL;
        default: mode_d = (sum_q == SUM_FOLLOW) ? OMSEL_EXTERNAL : OMSEL_NETWORK;
      endcase
    end else begin
      case (opm_q)
        OPM_PANEL: mode_d = OMSEL_PANEL;
        OPM_COMB_A, OPM_COMB_B: mode_d = OMSEL_COMBINED;
        OPM_FREE, OPM_EXT, OPM_LIVE, OPM_ILOCK: begin
          if (opm_q == OPM_ILOCK && !ilk_s) begin
            mode_d = OMSEL_EXTERNAL;
          end else if (toggle_cfg && opm_q == OPM_EXT) begin
            mode_d = OMSEL_NETWORK;
          end else if (toggle_cfg && opm_q == OPM_ILOCK) begin
            mode_d = sw.pu_ext ? OMSEL_EXTERNAL : OMSEL_PANEL;
          end else if (toggle_cfg && sw.pu_net_asg) begin
            if (sw.pu_net) begin
              mode_d = sw.ext_net ? OMSEL_NETWORK : OMSEL_PANEL;
            end else begin
              mode_d = net_to_panel_65 ? OMSEL_PANEL : OMSEL_NETWORK;
            end
          end else if (!toggle_cfg && sw.ext_net_asg) begin
            if (sw.ext_net) begin
              mode_d = net_to_panel_66 ? OMSEL_PANEL : OMSEL_NETWORK;
            end else if (opm_q == OPM_EXT) begin
              mode_d = OMSEL_EXTERNAL;
            end else if (sw.pu_net_asg) begin
              mode_d = sw.pu_net ? OMSEL_PANEL : OMSEL_NETWORK;
            end else begin
              mode_d = sw.pu_ext ? OMSEL_EXTERNAL : OMSEL_PANEL;
            end
          end else if (opm_q == OPM_EXT) begin
            mode_d = (mode_q == OMSEL_NETWORK) ? OMSEL_NETWORK : OMSEL_EXTERNAL;
          end else if (sw.pu_ext_asg && !toggle_cfg) begin
            mode_d = sw.pu_ext ? OMSEL_EXTERNAL : OMSEL_PANEL;
          end else if (toggle_cfg && mode_q == OMSEL_EXTERNAL) begin
            mode_d = OMSEL_NETWORK;
          end
        end
        default: mode_d = mode_q;
      endcase
    end
  end

  // ==========================================================================
  // mode register and output stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= OMSEL_EXTERNAL;
    end else if (start_now || stopped || opm_q == OPM_LIVE) begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= opm_q == OPM_ILOCK && ilk_s && mode_q == OMSEL_EXTERNAL;
    end
  end

  assign stat_out.mode = mode_q;
  assign stat_out.output_stop = stop_q;

  // ==========================================================================
  // assertions
  a_fixed_panel: assert property (@(posedge pclk) disable iff (!presetn)
    opm_q == OPM_PANEL && stopped |=> mode_q == OMSEL_PANEL)
    else $error("panel mode not held");
  a_fixed_comb: assert property (@(posedge pclk) disable iff (!presetn)
    (opm_q == OPM_COMB_A || opm_q == OPM_COMB_B) && stopped |=> mode_q == OMSEL_COMBINED)
    else $error("combined mode not held");
  a_ilock_force: assert property (@(posedge pclk) disable iff (!presetn)
    opm_q == OPM_ILOCK && !ilk_s && stopped && !start_now |=> mode_q == OMSEL_EXTERNAL)
    else $error("external not forced");
  a_output_stop: assert property (@(posedge pclk) disable iff (!presetn)
    stop_q == $past(opm_q == OPM_ILOCK && ilk_s && mode_q == OMSEL_EXTERNAL))
    else $error("output stop wrong");
  a_run_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !stopped && opm_q != OPM_LIVE && !start_now |=> $stable(mode_q))
    else $error("mode changed while running");
  a_net_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    opm_q == OPM_EXT && toggle_cfg && !start_now && stopped |=> mode_q == OMSEL_NETWORK)
    else $error("network not fixed");
  a_no_ext_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (opm_q == OPM_FREE || opm_q == OPM_LIVE) && toggle_cfg && !start_now && stopped
    |=> mode_q != OMSEL_EXTERNAL)
    else $error("external reached in toggle setup");
  a_bad_opmode: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && pwrite && paddr == OFS_OPMODE && pwdata[2:0] == OPM_BAD
    ##1 psel && penable |=> opm_q == $past(opm_q, 2))
    else $error("illegal select stored");
  a_sum_lock: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && pwrite && paddr == OFS_STARTUP && usergrp_q && !comm_option_fitted
    |=> pslverr ##1 $stable(sum_q))
    else $error("start-up write not refused");
  a_live_switch: assert property (@(posedge pclk) disable iff (!presetn)
    opm_q == OPM_LIVE && !stopped |=> mode_q == $past(mode_d))
    else $error("switch-over mode did not follow");
  c_network: cover property (@(posedge pclk) disable iff (!presetn)
    mode_q == OMSEL_NETWORK);
  c_panel_65: cover property (@(posedge pclk) disable iff (!presetn)
    toggle_cfg && sw.pu_net ##1 mode_q == OMSEL_PANEL);
  c_stop: cover property (@(posedge pclk) disable iff (!presetn) stop_q);
endmodule : omsel_top

// ==== sim/omsel_tb_top.sv ====
// omsel_tb_top: self-checking bench for the operation mode selector
module omsel_tb_top
  import omsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pu_interlock_in, ilock = 1'b0;
  logic [6:0] terminal_in;
  logic motor_running = 1'b0, start_cmd = 1'b0, comm_option_fitted = 1'b0;
  logic power_restore = 1'b0;
  omsel_sw_t sw = '0;
  omsel_stat_t stat_out;
  int err_total = 0, n_compared = 0;
  always #12.5 pclk = ~pclk;
  omsel_top #(.NUM_TERM(7)) omsel_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .terminal_in(terminal_in),
    .pu_interlock_in(pu_interlock_in), .motor_running(motor_running),
    .start_cmd(start_cmd), .comm_option_fitted(comm_option_fitted),
    .power_restore(power_restore), .stat_out(stat_out));
  omsel_term_model #(.NUM_TERM(7)) omsel_term_model_inst (.pclk(pclk), .presetn(presetn),
    .sw(sw), .ilock(ilock), .terminal_in(terminal_in), .pu_interlock_in(pu_interlock_in));
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk({31'h0, err}, {31'h0, e});
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask : rdc
  task automatic term(input logic pe, input logic pn, input logic en, input logic il);
    @(posedge pclk);
    sw <= '{pu_net: pn, ext_net: en, pu_ext: pe, default: 1'b1};
    ilock <= il;
  endtask : term
  task automatic mchk(input omsel_mode_t e);
    repeat (6) @(posedge pclk);
    chk({30'h0, stat_out.mode}, {30'h0, e});
  endtask : mchk
  task automatic run(input logic r);
    @(posedge pclk);
    motor_running <= r;
    start_cmd <= r;
  endtask : run
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    mchk(OMSEL_EXTERNAL);
    for (int i = 0; i < 4; i++) rdc(OFS_OPMODE + 8'(4 * i), 32'h0);
    wr(8'h40, 32'h0, 1'b1);
    wr(OFS_STATUS, 32'h0, 1'b1);
    wr(OFS_OPMODE, 32'h5, 1'b1);
    rdc(OFS_OPMODE, 32'h0);
    wr(OFS_USERGRP, 32'h1, 1'b0);
    wr(OFS_STARTUP, 32'h1, 1'b1);
    comm_option_fitted <= 1'b1;
    wr(OFS_STARTUP, 32'h1, 1'b0);
    rdc(OFS_STARTUP, 32'h1);
    @(posedge pclk) power_restore <= 1'b1;
    @(posedge pclk) power_restore <= 1'b0;
    mchk(OMSEL_NETWORK);
    comm_option_fitted <= 1'b0;
    wr(OFS_USERGRP, 32'h0, 1'b0);
    wr(OFS_STARTUP, 32'h0, 1'b0);
  endtask : t_regs
  task automatic t_extnet();
    logic [2:0] op [3] = '{OPM_PANEL, OPM_COMB_A, OPM_COMB_B};
    omsel_mode_t ex [3] = '{OMSEL_PANEL, OMSEL_COMBINED, OMSEL_COMBINED};
    wr(OFS_FUNC_BASE, {24'h0, FN_PU_EXT}, 1'b0);
    wr(OFS_FUNC_BASE + 8'h08, {24'h0, FN_EXT_NET}, 1'b0);
    term(1'b1, 1'b0, 1'b1, 1'b0); mchk(OMSEL_NETWORK);
    term(1'b1, 1'b0, 1'b0, 1'b0); mchk(OMSEL_EXTERNAL);
    term(1'b0, 1'b0, 1'b0, 1'b0); mchk(OMSEL_PANEL);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_OPMODE, {29'h0, op[i]}, 1'b0);
      term(1'b1, 1'b0, 1'b1, 1'b1); mchk(ex[i]);
    end
    wr(OFS_OPMODE, {29'h0, OPM_FREE}, 1'b0);
    wr(OFS_NETSRC, 32'h1, 1'b0);
    term(1'b0, 1'b0, 1'b1, 1'b0); mchk(OMSEL_PANEL);
    comm_option_fitted <= 1'b1;
    mchk(OMSEL_NETWORK);
    comm_option_fitted <= 1'b0;
    wr(OFS_NETSRC, 32'h0, 1'b0);
    wr(OFS_OPMODE, {29'h0, OPM_EXT}, 1'b0);
    term(1'b0, 1'b0, 1'b0, 1'b0); mchk(OMSEL_EXTERNAL);
    wr(OFS_OPMODE, {29'h0, OPM_ILOCK}, 1'b0);
    term(1'b0, 1'b0, 1'b1, 1'b0); mchk(OMSEL_EXTERNAL);
    term(1'b0, 1'b0, 1'b1, 1'b1); mchk(OMSEL_NETWORK);
    term(1'b1, 1'b0, 1'b0, 1'b1); mchk(OMSEL_EXTERNAL);
    chk({31'h0, stat_out.output_stop}, 32'h1);
    rdc(OFS_STATUS, {29'h0, 1'b1, OMSEL_EXTERNAL});
    wr(OFS_OPMODE, {29'h0, OPM_FREE}, 1'b0);
    mchk(OMSEL_EXTERNAL);
    chk({31'h0, stat_out.output_stop}, 32'h0);
  endtask : t_extnet
  task automatic t_punet();
    wr(OFS_FUNC_BASE + 8'h04, {24'h0, FN_PU_NET}, 1'b0);
    wr(OFS_STARTUP, {28'h0, SUM_TOGGLE}, 1'b0);
    term(1'b1, 1'b1, 1'b0, 1'b0); mchk(OMSEL_PANEL);
    comm_option_fitted <= 1'b1;
    term(1'b1, 1'b0, 1'b0, 1'b0); mchk(OMSEL_NETWORK);
    term(1'b0, 1'b0, 1'b0, 1'b0); mchk(OMSEL_PANEL);
    term(1'b1, 1'b1, 1'b1, 1'b0); mchk(OMSEL_NETWORK);
    wr(OFS_OPMODE, {29'h0, OPM_EXT}, 1'b0);
    term(1'b0, 1'b1, 1'b0, 1'b0); mchk(OMSEL_NETWORK);
    wr(OFS_OPMODE, {29'h0, OPM_FREE}, 1'b0);
  endtask : t_punet
  task automatic t_run();
    term(1'b1, 1'b1, 1'b0, 1'b0); mchk(OMSEL_PANEL);
    run(1'b1);
    term(1'b1, 1'b0, 1'b0, 1'b0); mchk(OMSEL_PANEL);
    wr(OFS_OPMODE, {29'h0, OPM_LIVE}, 1'b1);
    run(1'b0);
    mchk(OMSEL_NETWORK);
    wr(OFS_OPMODE, {29'h0, OPM_LIVE}, 1'b0);
    run(1'b1);
    term(1'b1, 1'b1, 1'b0, 1'b0); mchk(OMSEL_PANEL);
    run(1'b0);
    term(1'b1, 1'b0, 1'b0, 1'b0); mchk(OMSEL_NETWORK);
    comm_option_fitted <= 1'b0;
    mchk(OMSEL_PANEL);
  endtask : t_run
  // ==========================================================================
  // sequence, watchdog and verdict
  task automatic close_out();
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_extnet();
    t_punet();
    t_run();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    close_out();
  end
endmodule : omsel_tb_top

// ==== sim/omsel_term_model.sv ====
// omsel_term_model: terminal switches and interlock seen by the selector
module omsel_term_model
  import omsel_pkg::*;
#(
  parameter int unsigned NUM_TERM = 7
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requested levels
  input wire omsel_sw_t sw,
  input wire logic ilock,
  // terminal pins
  output logic [NUM_TERM-1:0] terminal_in,
  output logic pu_interlock_in
);
  // ==========================================================================
  // terminal 0 panel/external, 1 panel/network, 2 external/network
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      terminal_in <= '0;
      pu_interlock_in <= 1'b0;
    end else begin
      terminal_in <= NUM_TERM'({sw.ext_net & sw.ext_net_asg, sw.pu_net & sw.pu_net_asg,
                                sw.pu_ext & sw.pu_ext_asg});
      pu_interlock_in <= ilock;
    end
  end
endmodule : omsel_term_model
